// File: verilog/pattern_ram_loader_player.sv
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/1ps
// Pattern memory with block loader, Wishbone register file and playback sequencer
module pattern_ram_loader_player (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq,
    output logic             mod_data,
    output logic             rf_gate,
    output logic             event_out,
    output logic             restart_mark
);
    localparam int AW = pattern_memory_pkg::ADDR_W;

    // Full 8 Mbyte array; the small configuration only limits the usable range
    logic [7:0] mem [0:(1<<AW)-1];

    logic [2:0]          ctrl_r;
    logic [15:0]         div_r;
    logic [15:0]         div_cnt_r;
    logic                present_r;
    logic                error_r;
    logic [31:0]         err_code_r;
    logic [pattern_memory_pkg::IRQ_W-1:0] irq_stat_r;
    logic [pattern_memory_pkg::IRQ_W-1:0] irq_en_r;
    logic [AW-1:0]       play_addr_r;
    logic                playing_r;

    logic                bus_req;
    logic                bus_wr;
    logic                dl_valid;
    logic                fmt_change;
    logic                tick;
    logic [31:0]         capacity;
    logic [7:0]          cur_byte;
    logic                at_end;
    logic                p_wr_en;
    logic [AW-1:0]       p_wr_addr;
    logic [7:0]          p_wr_data;
    logic                p_done;
    logic                p_too_much;
    logic                p_syntax;
    logic                p_busy;
    logic [pattern_memory_pkg::IRQ_W-1:0] events;
    logic [pattern_memory_pkg::IRQ_W-1:0] clr_mask;

    // Byte-lane merge for a register write
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction

    // Request decode: one access per ack, write takes effect with the ack
    assign bus_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr     = bus_req && wb_we_i;
    assign dl_valid   = bus_wr && wb_adr_i == pattern_memory_pkg::OFS_DL_DATA && wb_sel_i[0];
    assign fmt_change = bus_wr && wb_adr_i == pattern_memory_pkg::OFS_CTRL && wb_sel_i[0]
                        && wb_dat_i[pattern_memory_pkg::CTRL_FORMAT];
    assign capacity   = ctrl_r[pattern_memory_pkg::CTRL_BIG] ? pattern_memory_pkg::CAP_LARGE : pattern_memory_pkg::CAP_SMALL;

    block_header_parser u_parser (
        .clk        (clk),
        .rst        (rst),
        .byte_valid (dl_valid),
        .byte_in    (wb_dat_i[7:0]),
        .capacity   (capacity),
        .abort      (fmt_change),
        .wr_en      (p_wr_en),
        .wr_addr    (p_wr_addr),
        .wr_data    (p_wr_data),
        .done       (p_done),
        .too_much   (p_too_much),
        .syntax_err (p_syntax),
        .busy       (p_busy)
    );

    // Payload store, bytes kept exactly as sent
    always_ff @(posedge clk) begin
        if (p_wr_en) begin
            mem[p_wr_addr] <= p_wr_data;
        end
    end

    // Bus handshake; ack drops the cycle after it is given
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // Read data mux; unmapped and write-only offsets read as zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h0;
        end else if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                pattern_memory_pkg::OFS_CTRL:      wb_dat_o <= {29'h0, ctrl_r};
                pattern_memory_pkg::OFS_STATUS:    wb_dat_o <= {29'h0, error_r, p_busy, present_r};
                pattern_memory_pkg::OFS_ERR_CODE:  wb_dat_o <= err_code_r;
                pattern_memory_pkg::OFS_IRQ_STAT:  wb_dat_o <= {28'h0, irq_stat_r};
                pattern_memory_pkg::OFS_IRQ_EN:    wb_dat_o <= {28'h0, irq_en_r};
                pattern_memory_pkg::OFS_PLAY_ADDR: wb_dat_o <= {9'h0, play_addr_r};
                pattern_memory_pkg::OFS_DATA_DIV:  wb_dat_o <= {16'h0, div_r};
                default:                 wb_dat_o <= 32'h0;
            endcase
        end
    end

    // Control register; the format bit is a strobe and never stored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= pattern_memory_pkg::CTRL_RESET;
        end else if (bus_wr && wb_adr_i == pattern_memory_pkg::OFS_CTRL && wb_sel_i[0]) begin
            ctrl_r <= {1'b0, wb_dat_i[pattern_memory_pkg::CTRL_BIG], wb_dat_i[pattern_memory_pkg::CTRL_PLAY]};
        end
    end

    // Data clock divider setting
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_r <= pattern_memory_pkg::DIV_RESET;
        end else if (bus_wr && wb_adr_i == pattern_memory_pkg::OFS_DATA_DIV) begin
            div_r <= 16'(lane_merge({16'h0, div_r}, wb_dat_i, wb_sel_i));
        end
    end

    // Interrupt enables
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_en_r <= '0;
        end else if (bus_wr && wb_adr_i == pattern_memory_pkg::OFS_IRQ_EN && wb_sel_i[0]) begin
            irq_en_r <= wb_dat_i[pattern_memory_pkg::IRQ_W-1:0];
        end
    end

    // Pattern present flag; power-up leaves no pattern, a mode change discards it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            present_r <= 1'b0;
        end else if (fmt_change) begin
            present_r <= 1'b0;
        end else if (p_done) begin
            present_r <= 1'b1;
        end else if (p_wr_en && p_wr_addr == '0) begin
            present_r <= 1'b0; // Old pattern is being overwritten
        end
    end

    // Error flag and code, kept until the next accepted download
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            error_r    <= 1'b0;
            err_code_r <= 32'h0;
        end else if (p_too_much) begin
            error_r    <= 1'b1;
            err_code_r <= pattern_memory_pkg::ERR_TOO_MUCH;
        end else if (p_done) begin
            error_r    <= 1'b0;
            err_code_r <= 32'h0;
        end
    end

    // Data clock: one tick every div_r+1 system clocks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt_r <= 16'h0;
        end else if (div_cnt_r >= div_r) begin
            div_cnt_r <= 16'h0;
        end else begin
            div_cnt_r <= div_cnt_r + 16'h1;
        end
    end

    assign tick = div_cnt_r >= div_r;

    // Playback is held off while a download is writing memory
    assign cur_byte = mem[play_addr_r];
    assign at_end   = cur_byte[pattern_memory_pkg::BIT_RESTART]
                      || 32'({9'h0, play_addr_r} + 32'h1) >= capacity;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            playing_r <= 1'b0;
        end else begin
            playing_r <= ctrl_r[pattern_memory_pkg::CTRL_PLAY] && present_r && !p_busy;
        end
    end

    // Sequencer address: one byte per data clock, back to zero at a pattern end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            play_addr_r <= '0;
        end else if (!playing_r) begin
            play_addr_r <= '0;
        end else if (tick) begin
            play_addr_r <= at_end ? '0 : play_addr_r + 1'b1;
        end
    end

    // Byte decode onto the outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mod_data     <= 1'b0;
            rf_gate      <= 1'b0;
            restart_mark <= 1'b0;
        end else if (!playing_r) begin
            mod_data     <= 1'b0;
            rf_gate      <= 1'b0;
            restart_mark <= 1'b0;
        end else if (tick) begin
            // Data is forced low in off slots since its value there means nothing
            mod_data     <= cur_byte[pattern_memory_pkg::BIT_DATA] && cur_byte[pattern_memory_pkg::BIT_BURST];
            rf_gate      <= cur_byte[pattern_memory_pkg::BIT_BURST];
            restart_mark <= cur_byte[pattern_memory_pkg::BIT_RESTART];
        end
    end

    // Event connector level flips on each byte with its event bit set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            event_out <= 1'b0;
        end else if (playing_r && tick && cur_byte[pattern_memory_pkg::BIT_EVENT]) begin
            event_out <= !event_out;
        end
    end

    // Sticky interrupt status; a new event wins over a clear in the same cycle
    assign events = {p_syntax, playing_r && tick && at_end, p_too_much, p_done};
    assign clr_mask = (bus_wr && wb_adr_i == pattern_memory_pkg::OFS_IRQ_CLR && wb_sel_i[0]) ?
                      wb_dat_i[pattern_memory_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~clr_mask) | events;
        end
    end

    // Level interrupt from a flop, updated on the same edge as the status
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_stat_r & ~clr_mask) | events) & irq_en_r);
        end
    end

endmodule // pattern_ram_loader_player

// File: verilog/pattern_memory_pkg.sv
// Overview of operation
// - Each pattern memory location is one byte whose bit 0 is the modulation data and bits 1 to 7 are control.
// - The pattern memory holds 1 Mbyte or 8 Mbytes, chosen by the fitted memory configuration.
// - A block download is a hash marker, one digit counting the length digits, the length digits, then that many bytes.
// - Payload bytes are stored exactly as received, with no text parsing.
// - A download longer than the memory capacity is rejected and reported as error code -223, too much data.
// - Playback drives bit 0 as modulation data, which is unspecified while burst bit 2 is 0.
// - Burst bit 2 gates the RF output, 1 on and 0 off.
// - A 1 in bit 6 causes a level transition on the event output.
// - Bit 7 at 0 advances to the next address; bit 7 at 1 ends the pattern and restarts from address zero.
// - Pattern contents are lost on power cycling and are discarded when the mode changes to a new framed format.
// - A query reports whether a user-defined pattern is currently loaded.
package pattern_memory_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_DL_DATA   = 8'h04;
    localparam logic [7:0] OFS_STATUS    = 8'h08;
    localparam logic [7:0] OFS_ERR_CODE  = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLR   = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h18;
    localparam logic [7:0] OFS_PLAY_ADDR = 8'h1c;
    localparam logic [7:0] OFS_DATA_DIV  = 8'h20;

    // Control bits
    localparam int CTRL_PLAY   = 0;
    localparam int CTRL_BIG    = 1;
    localparam int CTRL_FORMAT = 2;

    // Status bits
    localparam int ST_PRESENT = 0;
    localparam int ST_BUSY    = 1;
    localparam int ST_ERROR   = 2;

    // Interrupt event bits
    localparam int IRQ_W       = 4;
    localparam int EV_DONE     = 0;
    localparam int EV_TOO_MUCH = 1;
    localparam int EV_RESTART  = 2;
    localparam int EV_SYNTAX   = 3;

    // Pattern byte fields
    localparam int BIT_DATA    = 0;
    localparam int BIT_BURST   = 2;
    localparam int BIT_EVENT   = 6;
    localparam int BIT_RESTART = 7;

    // Memory geometry
    localparam int          ADDR_W    = 23;
    localparam logic [31:0] CAP_SMALL = 32'h0010_0000;
    localparam logic [31:0] CAP_LARGE = 32'h0080_0000;

    // Block download framing
    localparam logic [7:0]  CH_HASH    = 8'h23;
    localparam logic [7:0]  CH_ZERO    = 8'h30;
    localparam logic [7:0]  CH_NINE    = 8'h39;
    localparam logic [31:0] ERR_TOO_MUCH = 32'hffff_ff21;

    // Reset values
    localparam logic [2:0]  CTRL_RESET = 3'h0;
    localparam logic [15:0] DIV_RESET  = 16'h0000;

    typedef enum logic [3:0] {
        P_IDLE    = 4'b0001,
        P_NDIG    = 4'b0010,
        P_LEN     = 4'b0100,
        P_PAYLOAD = 4'b1000
    } parse_state_t;

endpackage

// File: verilog/block_header_parser.sv
`timescale 1ns/1ps
// Walks the block download byte stream and produces memory writes
module block_header_parser (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     byte_valid,
    input  wire logic [7:0]               byte_in,
    input  wire logic [31:0]              capacity,
    input  wire logic                     abort,
    output logic                          wr_en,
    output logic [pattern_memory_pkg::ADDR_W-1:0]   wr_addr,
    output logic [7:0]                    wr_data,
    output logic                          done,
    output logic                          too_much,
    output logic                          syntax_err,
    output logic                          busy
);
    pattern_memory_pkg::parse_state_t state_r;
    logic [3:0]  ndig_r;
    logic [31:0] len_r;
    logic [31:0] cnt_r;
    logic        reject_r;

    function automatic logic is_digit(input logic [7:0] c);
        return (c >= pattern_memory_pkg::CH_ZERO) && (c <= pattern_memory_pkg::CH_NINE);
    endfunction

    function automatic logic [3:0] digit_val(input logic [7:0] c);
        logic [7:0] d;
        d = c - pattern_memory_pkg::CH_ZERO;
        return d[3:0];
    endfunction

    // Header walk and payload count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r  <= pattern_memory_pkg::P_IDLE;
            ndig_r   <= 4'h0;
            len_r    <= 32'h0;
            cnt_r    <= 32'h0;
            reject_r <= 1'b0;
        end else if (abort) begin
            state_r <= pattern_memory_pkg::P_IDLE;
        end else if (byte_valid) begin
            case (state_r)
                pattern_memory_pkg::P_IDLE: begin
                    if (byte_in == pattern_memory_pkg::CH_HASH) begin
                        state_r <= pattern_memory_pkg::P_NDIG;
                    end
                    len_r <= 32'h0;
                    cnt_r <= 32'h0;
                end
                pattern_memory_pkg::P_NDIG: begin
                    if (is_digit(byte_in) && digit_val(byte_in) != 4'h0) begin
                        ndig_r  <= digit_val(byte_in);
                        state_r <= pattern_memory_pkg::P_LEN;
                    end else begin
                        state_r <= pattern_memory_pkg::P_IDLE;
                    end
                end
                pattern_memory_pkg::P_LEN: begin
                    if (!is_digit(byte_in)) begin
                        state_r <= pattern_memory_pkg::P_IDLE;
                    end else begin
                        len_r  <= 32'(len_r * 32'd10) + 32'(digit_val(byte_in));
                        ndig_r <= ndig_r - 4'h1;
                        if (ndig_r == 4'h1) begin
                            reject_r <= (32'(len_r * 32'd10) + 32'(digit_val(byte_in))) > capacity;
                            state_r  <= ((32'(len_r * 32'd10) + 32'(digit_val(byte_in))) == 32'h0) ?
                                        pattern_memory_pkg::P_IDLE : pattern_memory_pkg::P_PAYLOAD;
                        end
                    end
                end
                pattern_memory_pkg::P_PAYLOAD: begin
                    cnt_r <= cnt_r + 32'h1;
                    if (cnt_r + 32'h1 == len_r) begin
                        state_r <= pattern_memory_pkg::P_IDLE;
                    end
                end
                default: state_r <= pattern_memory_pkg::P_IDLE;
            endcase
        end
    end

    // Rejected payloads are still swallowed so the stream stays in step
    always_comb begin
        wr_en      = byte_valid && !abort && state_r == pattern_memory_pkg::P_PAYLOAD && !reject_r;
        wr_addr    = cnt_r[pattern_memory_pkg::ADDR_W-1:0];
        wr_data    = byte_in;
        done       = byte_valid && !abort && state_r == pattern_memory_pkg::P_PAYLOAD && !reject_r
                     && (cnt_r + 32'h1 == len_r);
        too_much   = byte_valid && !abort && state_r == pattern_memory_pkg::P_LEN && is_digit(byte_in)
                     && ndig_r == 4'h1 && ((32'(len_r * 32'd10) + 32'(digit_val(byte_in))) > capacity);
        syntax_err = byte_valid && !abort
                     && ((state_r == pattern_memory_pkg::P_NDIG && !(is_digit(byte_in) && digit_val(byte_in) != 4'h0))
                     || (state_r == pattern_memory_pkg::P_LEN && !is_digit(byte_in)));
        busy       = state_r != pattern_memory_pkg::P_IDLE;
    end

endmodule // block_header_parser

// File: tb/pattern_memory_player_checker.sv
`timescale 1ns/1ps
// Port-level watcher for the pattern player; sees only the top ports
module pattern_memory_player_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        irq,
    input wire logic        mod_data,
    input wire logic        rf_gate,
    input wire logic        event_out,
    input wire logic        restart_mark
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Bus handshake: one answer per request, exactly one cycle later
    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    // Unmapped space reads as zero; writes leave the read data alone
    a_unmapped_reads_zero: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i > 8'h20) |-> wb_dat_o == 32'h0)
        else $error("unmapped read returned nonzero data");
    a_rdata_holds: assert property (wb_ack_o && $past(wb_we_i) |-> $stable(wb_dat_o))
        else $error("read data moved on a write");
    // Modulation bit is meaningless, hence forced low, while the burst gate is off
    a_data_needs_burst: assert property (mod_data |-> rf_gate)
        else $error("data bit high with burst gate low");
    // Masking every source drops the level output right behind the register update
    a_irq_masked_off: assert property (wb_ack_o && $past(wb_we_i && wb_adr_i == pattern_memory_pkg::OFS_IRQ_EN
        && wb_sel_i[0] && wb_dat_i[3:0] == 4'h0) |=> !irq)
        else $error("interrupt still high with all sources masked");
    // Stopping playback or changing format silences the player within a few cycles
    a_halt_quiets: assert property (wb_ack_o && $past(wb_we_i && wb_adr_i == pattern_memory_pkg::OFS_CTRL && wb_sel_i[0]
        && (!wb_dat_i[0] || wb_dat_i[2])) |-> ##[1:8] (!rf_gate && !mod_data && !restart_mark))
        else $error("player outputs still active after stop");
endmodule // pattern_memory_player_checker

bind pattern_ram_loader_player pattern_memory_player_checker pattern_memory_player_checker_inst (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq(irq), .mod_data(mod_data), .rf_gate(rf_gate),
    .event_out(event_out), .restart_mark(restart_mark)
);

// File: tb/host_link_model.sv
`timescale 1ns/1ps
// Remote host: Wishbone master that also frames block downloads
module host_link_model (
    input  wire logic        clk,
    input  wire logic        ack,
    input  wire logic [31:0] dat_r,
    output logic             cyc,
    output logic             stb,
    output logic             we,
    output logic [7:0]       adr,
    output logic [3:0]       sel,
    output logic [31:0]      dat_w
);
    // Bus idles at time zero
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        dat_w = 32'h0;
    end

    // One classic cycle; no cycle count is assumed, the bench timeout ends a hang
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        dat_w <= d;
        // Ack is looked at while settled, then taken at the rising edge that samples it high
        do @(negedge clk); while (ack !== 1'b1);
        @(posedge clk);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // Reserved bits fixed, restart flag only on the closing byte
    function automatic logic [7:0] pat_byte(input logic d, input logic b, input logic e, input logic last);
        return {last, e, 1'b0, 1'b1, 1'b0, b, 1'b0, d};
    endfunction

    // Raw characters, one per bus write
    task automatic send_text(input string s);
        logic [31:0] q;
        for (int i = 0; i < s.len(); i++) xfer(1'b1, pattern_memory_pkg::OFS_DL_DATA, {24'h0, s[i]}, q);
    endtask

    // Marker, digit count, length digits, then the binary payload untouched
    task automatic send_block(input logic [7:0] body[$]);
        string len;
        logic [31:0] q;
        len = $sformatf("%0d", body.size());
        send_text({"#", $sformatf("%0d", len.len()), len});
        foreach (body[i]) xfer(1'b1, pattern_memory_pkg::OFS_DL_DATA, {24'h0, body[i]}, q);
    endtask
endmodule // host_link_model

// File: tb/pattern_ram_loader_player_tb.sv
`timescale 1ns/1ps
// Self-checking bench: host model drives the bus, counts model the player
module pattern_ram_loader_player_tb;
    logic        clk;
    logic        rst;
    logic        cyc, stb, we, ack, irq, mod_data, rf_gate, event_out, restart_mark;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat_w, dat_r;
    int          err_total = 0;
    int          total_checks = 0;
    int          cycles = 0;

    pattern_ram_loader_player pattern_ram_loader_player_inst (
        .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .irq(irq),
        .mod_data(mod_data), .rf_gate(rf_gate), .event_out(event_out), .restart_mark(restart_mark)
    );
    host_link_model host_link_model_inst (
        .clk(clk), .ack(ack), .dat_r(dat_r), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat_w(dat_w)
    );

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Hang guard, far above the length of the sequence
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        host_link_model_inst.xfer(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] q;
        host_link_model_inst.xfer(1'b0, a, 32'h0, q);
        chk(q & mask, exp);
    endtask

    // Level output follows the status on the same edge and the enable register one cycle later
    task automatic irq_chk(input logic e);
        @(negedge clk);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    // Load a random pattern, then measure one full period of playback against counts
    task automatic play_round(input int div, input int len);
        logic [7:0]  body[$];
        logic [7:0]  b;
        logic [31:0] r;
        logic        ev_prev;
        int          n_rf, n_mod, n_ev, c_rf, c_mod, c_ev, c_rs;
        n_rf = 0; n_mod = 0; n_ev = 0; c_rf = 0; c_mod = 0; c_ev = 0; c_rs = 0;
        for (int i = 0; i < len; i++) begin
            r = $urandom();
            b = host_link_model_inst.pat_byte(r[0], r[1], r[2], i == len - 1);
            body.push_back(b);
            n_rf += int'(b[2]);
            n_mod += int'(b[0] & b[2]);
            n_ev += int'(b[6]);
        end
        wr(pattern_memory_pkg::OFS_CTRL, 32'h4);
        wr(pattern_memory_pkg::OFS_DATA_DIV, 32'(div));
        wr(pattern_memory_pkg::OFS_IRQ_EN, 32'h1);
        host_link_model_inst.send_block(body);
        rd_chk(pattern_memory_pkg::OFS_STATUS, 32'h7, 32'h1);
        rd_chk(pattern_memory_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
        irq_chk(1'b1);
        wr(pattern_memory_pkg::OFS_IRQ_EN, 32'h0);
        irq_chk(1'b0);
        wr(pattern_memory_pkg::OFS_IRQ_EN, 32'h1);
        irq_chk(1'b1);
        wr(pattern_memory_pkg::OFS_IRQ_CLR, 32'h1);
        irq_chk(1'b0);
        rd_chk(pattern_memory_pkg::OFS_IRQ_STAT, 32'h1, 32'h0);
        wr(pattern_memory_pkg::OFS_CTRL, 32'h1);
        while (restart_mark !== 1'b1) @(negedge clk);
        ev_prev = event_out;
        repeat (len * (div + 1)) begin
            @(negedge clk);
            c_rf += int'(rf_gate === 1'b1);
            c_mod += int'(mod_data === 1'b1);
            c_rs += int'(restart_mark === 1'b1);
            c_ev += int'(event_out !== ev_prev);
            ev_prev = event_out;
        end
        chk(32'(c_rf), 32'(n_rf * (div + 1)));
        chk(32'(c_mod), 32'(n_mod * (div + 1)));
        chk(32'(c_ev), 32'(n_ev));
        chk(32'(c_rs), 32'(div + 1));
        rd_chk(pattern_memory_pkg::OFS_IRQ_STAT, 32'h4, 32'h4);
        wr(pattern_memory_pkg::OFS_CTRL, 32'h0);
        rd_chk(pattern_memory_pkg::OFS_PLAY_ADDR, 32'h7f_ffff, 32'h0);
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        void'($urandom(32'hb8ea5395));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_chk(pattern_memory_pkg::OFS_CTRL, 32'h7, 32'h0);
        rd_chk(pattern_memory_pkg::OFS_DATA_DIV, 32'hffff, 32'h0);
        rd_chk(pattern_memory_pkg::OFS_IRQ_EN, 32'hf, 32'h0);
        rd_chk(pattern_memory_pkg::OFS_STATUS, 32'h7, 32'h0);
        rd_chk(8'h24, 32'hffff_ffff, 32'h0);
        play_round(0, 3 + int'($urandom_range(0, 5)));
        play_round(3, 3 + int'($urandom_range(0, 5)));
        // One byte over the small capacity: rejected, old pattern kept
        wr(pattern_memory_pkg::OFS_IRQ_CLR, 32'hf);
        host_link_model_inst.send_text("#71048577");
        rd_chk(pattern_memory_pkg::OFS_STATUS, 32'h5, 32'h5);
        rd_chk(pattern_memory_pkg::OFS_ERR_CODE, 32'hffff_ffff, pattern_memory_pkg::ERR_TOO_MUCH);
        rd_chk(pattern_memory_pkg::OFS_IRQ_STAT, 32'h2, 32'h2);
        wr(pattern_memory_pkg::OFS_CTRL, 32'h4);
        rd_chk(pattern_memory_pkg::OFS_STATUS, 32'h3, 32'h0);
        // Large memory takes the same length, refuses one byte over its own size
        wr(pattern_memory_pkg::OFS_CTRL, 32'h6);
        host_link_model_inst.send_text("#71048577");
        rd_chk(pattern_memory_pkg::OFS_STATUS, 32'h6, 32'h6);
        wr(pattern_memory_pkg::OFS_CTRL, 32'h6);
        host_link_model_inst.send_text("#78388609");
        rd_chk(pattern_memory_pkg::OFS_STATUS, 32'h4, 32'h4);
        // A zero digit count is a malformed header
        wr(pattern_memory_pkg::OFS_CTRL, 32'h4);
        wr(pattern_memory_pkg::OFS_IRQ_CLR, 32'hf);
        host_link_model_inst.send_text("#0");
        rd_chk(pattern_memory_pkg::OFS_IRQ_STAT, 32'h8, 32'h8);
        tally_and_finish();
    end
endmodule // pattern_ram_loader_player_tb
